// ---- dif_pkg.sv ----
// Shared constants, types and function codes of the drive input decoder.
// Assumes a single 25 MHz system clock; all users import this package whole.
package dif_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int FREQ_W  = 16;
    localparam int NTERM   = 4;
    localparam int FSEL_W  = 5;
    localparam int NFUNC   = 32;
    localparam int NPRESET = 16;
    localparam int NRAW    = 6;

    // Raw input vector positions
    localparam int RAW_FWD   = 0;
    localparam int RAW_REV   = 1;
    localparam int RAW_TERM0 = 2;

    // Terminal function codes
    localparam logic [FSEL_W-1:0] FN_FWD_REV       = 5'h00;
    localparam logic [FSEL_W-1:0] FN_STOP_KEY      = 5'h01;
    localparam logic [FSEL_W-1:0] FN_STEP1         = 5'h02;
    localparam logic [FSEL_W-1:0] FN_STEP2         = 5'h03;
    localparam logic [FSEL_W-1:0] FN_STEP3         = 5'h04;
    localparam logic [FSEL_W-1:0] FN_STEP4         = 5'h05;
    localparam logic [FSEL_W-1:0] FN_JOG_SEL       = 5'h06;
    localparam logic [FSEL_W-1:0] FN_RAMP_SWITCH   = 5'h07;
    localparam logic [FSEL_W-1:0] FN_BB_NO         = 5'h08;
    localparam logic [FSEL_W-1:0] FN_BB_NC         = 5'h09;
    localparam logic [FSEL_W-1:0] FN_RAMP_HOLD     = 5'h0A;
    localparam logic [FSEL_W-1:0] FN_OVERHEAT      = 5'h0B;
    localparam logic [FSEL_W-1:0] FN_FWD_JOG       = 5'h0C;
    localparam logic [FSEL_W-1:0] FN_REV_JOG       = 5'h0D;
    localparam logic [FSEL_W-1:0] FN_PID_IRESET    = 5'h0E;
    localparam logic [FSEL_W-1:0] FN_PID_DISABLE   = 5'h0F;
    localparam logic [FSEL_W-1:0] FN_EXT_FAULT_NO  = 5'h10;
    localparam logic [FSEL_W-1:0] FN_EXT_FAULT_NC  = 5'h11;
    localparam logic [FSEL_W-1:0] FN_AUX_ENABLE    = 5'h12;
    localparam logic [FSEL_W-1:0] FN_DC_BRAKE      = 5'h14;
    localparam logic [FSEL_W-1:0] FN_LOCAL_SELECT  = 5'h17;

    localparam logic [3:0]        AUX_FN_FREQ      = 4'h0;
    localparam logic [3:0]        FIRST_TERM_NUM   = 4'h5;

    // Timing
    localparam longint CLK_HZ              = 25_000_000;
    localparam longint JOG_CONFLICT_MS     = 500;
    localparam int     JOG_CONFLICT_CYCLES = int'(JOG_CONFLICT_MS * CLK_HZ / 64'd1000);
    localparam int     JOG_CNT_W           = 24;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        RUN_IDLE = 3'b001,
        RUN_FWD  = 3'b010,
        RUN_REV  = 3'b100
    } dif_run_t;

    typedef enum logic [2:0] {
        DISP_NORMAL    = 3'h0,
        DISP_FREQ_ERR  = 3'h1,
        DISP_BB_ALARM  = 3'h2,
        DISP_OVERHEAT  = 3'h3,
        DISP_EXT_FAULT = 3'h4
    } dif_disp_t;

    typedef struct packed {
        logic [NTERM-1:0][FSEL_W-1:0] term_fsel;
        logic                         run_source_select;
        logic                         reference_source_select;
        logic                         stop_method_select;
        logic [3:0]                   aux_analog_function_select;
        logic                         pid_feature_enable;
    } dif_cfg_t;

    typedef struct packed {
        logic run;
        logic reverse;
        logic jog;
        logic ramp_second;
        logic ramp_hold;
        logic output_block;
        logic coast_stop;
        logic dc_brake;
        logic pid_enable;
        logic pid_integ_reset;
        logic aux_enable;
    } dif_cmd_t;

    typedef struct packed {
        dif_disp_t  display;
        logic       fault;
        logic [3:0] fault_terminal;
        logic       local_mode;
        logic       remote_led;
    } dif_ind_t;

    localparam dif_cmd_t CMD_RST = '0;
    localparam dif_ind_t IND_RST = '{display: DISP_NORMAL, fault: 1'b0, fault_terminal: 4'h0,
                                     local_mode: 1'b0, remote_led: 1'b1};

endpackage

// ---- dif_decoder.sv ----
// Multi-function contact input decoder of a motor drive.
// Assumes raw contacts are asynchronous and the sequencer reports stop and ramp state.
//
// Notes on behaviour
// - Two-wire: forward, reverse, or stop
// - Both on: stop, flag error, recover after
// - Terminal five code 01 latches runs
// - Otherwise non-latching two-wire operation
// - Four step inputs binary select sixteen presets
// - Preset one: stored or analog by setting
// - Preset two: auxiliary input when setting zero
// - Ramp switch selects second ramp pair
// - Baseblock while running blocks, then resumes
// - Baseblock while decelerating coasts, stays stopped
// - Normally-open active on, normally-closed active off
// - Ramp hold freezes output frequency
// - Run off during hold: coast, remember frequency
// - Overheat input shows alarm, keeps running
// - Forward and reverse jog at jog frequency
// - Jog overrides every other frequency source
// - Both jogs over 500 ms stop drive
// - Integral reset input clears PID integrator
// - PID-disable input selects open loop
// - External fault blocks, coasts, names terminal
// - Auxiliary input enable, off under PID
// - DC braking when stopped; run cancels it
// - Local select takes panel, remote lamp off
// - Local to remote only while stopped
module dif_decoder
    import dif_pkg::*;
#(
    parameter int JOG_LIMIT = JOG_CONFLICT_CYCLES
) (
    input  wire logic                                mclk,
    input  wire logic                                nrst,
    input  wire logic                                clk_en,
    input  wire dif_cfg_t                            cfg,
    input  wire logic                                forward_run_switch,
    input  wire logic                                reverse_run_switch,
    input  wire logic [NTERM-1:0]                    term_pins,
    input  wire logic                                panel_run,
    input  wire logic                                panel_reverse,
    input  wire logic [FREQ_W-1:0]                   panel_freq,
    input  wire logic                                serial_run,
    input  wire logic                                serial_reverse,
    input  wire logic [FREQ_W-1:0]                   serial_freq,
    input  wire logic [NPRESET-1:0][FREQ_W-1:0]      preset_frequency,
    input  wire logic [FREQ_W-1:0]                   jog_frequency,
    input  wire logic [FREQ_W-1:0]                   analog_voltage_input,
    input  wire logic [FREQ_W-1:0]                   analog_current_input,
    input  wire logic [FREQ_W-1:0]                   aux_analog_input,
    input  wire logic [FREQ_W-1:0]                   output_frequency,
    input  wire logic                                drive_stopped,
    input  wire logic                                ramp_decelerating,
    input  wire logic                                fault_reset,
    output dif_cmd_t                                 cmd,
    output logic [FREQ_W-1:0]                        freq_ref,
    output logic [FREQ_W-1:0]                        held_frequency,
    output dif_ind_t                                 ind
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: three stages, level accepted when stages two and three agree
    logic [NRAW-1:0] raw;
    logic [NRAW-1:0] lvl;

    assign raw = {term_pins, reverse_run_switch, forward_run_switch};

    for (genvar i = 0; i < NRAW; i++) begin : g_sync
        logic s1_r;
        logic s2_r;
        logic s3_r;
        logic lvl_r;
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                s1_r  <= 1'b0;
                s2_r  <= 1'b0;
                s3_r  <= 1'b0;
                lvl_r <= 1'b0;
            end else if (clk_en) begin
                s1_r <= raw[i];
                s2_r <= s1_r;
                s3_r <= s2_r;
                // Glitch filter
                if (s2_r == s3_r) begin
                    lvl_r <= s3_r;
                end
            end
        end
        assign lvl[i] = lvl_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Function decode per terminal
    logic [NTERM-1:0][NFUNC-1:0] term_asg;
    logic [NTERM-1:0][NFUNC-1:0] term_on;
    logic [NTERM-1:0][NFUNC-1:0] term_off;
    logic [NTERM-1:0]            term_fault;

    for (genvar t = 0; t < NTERM; t++) begin : g_term
        assign term_asg[t]   = NFUNC'(1) << cfg.term_fsel[t];
        assign term_on[t]    = lvl[RAW_TERM0 + t] ? term_asg[t] : '0;
        assign term_off[t]   = lvl[RAW_TERM0 + t] ? '0 : term_asg[t];
        assign term_fault[t] = term_on[t][FN_EXT_FAULT_NO] | term_off[t][FN_EXT_FAULT_NC];
    end

    wire [NFUNC-1:0] fn_asg = term_asg[0] | term_asg[1] | term_asg[2] | term_asg[3];
    wire [NFUNC-1:0] fn_on  = term_on[0] | term_on[1] | term_on[2] | term_on[3];
    wire [NFUNC-1:0] fn_off = term_off[0] | term_off[1] | term_off[2] | term_off[3];

    wire baseblock   = fn_on[FN_BB_NO] | fn_off[FN_BB_NC];
    wire ext_fault   = |term_fault;
    wire ramp_hold   = fn_on[FN_RAMP_HOLD];
    wire overheat    = fn_on[FN_OVERHEAT];
    wire fwd_jog     = fn_on[FN_FWD_JOG];
    wire rev_jog     = fn_on[FN_REV_JOG];

    wire local_req   = fn_on[FN_LOCAL_SELECT];

    wire pid_enable  = cfg.pid_feature_enable & ~fn_on[FN_PID_DISABLE];
    wire aux_gate    = fn_asg[FN_AUX_ENABLE] ? fn_on[FN_AUX_ENABLE] : 1'b1;
    wire aux_enable  = aux_gate & ~pid_enable;

    // Lowest terminal wins
    wire [3:0] fault_term = term_fault[0] ? FIRST_TERM_NUM :
                            term_fault[1] ? FIRST_TERM_NUM + 4'h1 :
                            term_fault[2] ? FIRST_TERM_NUM + 4'h2 :
                                            FIRST_TERM_NUM + 4'h3;

    ////////////////////////////////////////////////////////////////////////
    // Terminal run commands
    // Filtered contact levels
    wire sw_fwd     = lvl[RAW_FWD];
    wire sw_rev     = lvl[RAW_REV];
    wire sustain    = (cfg.term_fsel[0] == FN_STOP_KEY);
    wire stop_key   = sustain & lvl[RAW_TERM0];

    wire conflict   = sw_fwd & sw_rev;

    dif_run_t run_st_r;
    dif_run_t run_st_nxt;

    always_comb begin
        run_st_nxt = run_st_r;
        case (run_st_r)
            RUN_IDLE: begin
                if (sustain && sw_fwd && !sw_rev && !stop_key) begin
                    run_st_nxt = RUN_FWD;
                end else if (sustain && sw_rev && !sw_fwd && !stop_key) begin
                    run_st_nxt = RUN_REV;
                end
            end
            RUN_FWD: begin
                if (!sustain || stop_key || sw_rev) begin
                    run_st_nxt = RUN_IDLE;
                end
            end
            RUN_REV: begin
                if (!sustain || stop_key || sw_fwd) begin
                    run_st_nxt = RUN_IDLE;
                end
            end
            default: run_st_nxt = RUN_IDLE;
        endcase
    end

    wire term_run = sustain ? (run_st_r != RUN_IDLE) : (sw_fwd ^ sw_rev);
    wire term_rev = sustain ? (run_st_r == RUN_REV) : sw_rev;

    ////////////////////////////////////////////////////////////////////////
    // Frequency selection
    wire [3:0] step = {fn_on[FN_STEP4], fn_on[FN_STEP3],
                       fn_on[FN_STEP2], fn_on[FN_STEP1]};

    // Saturating analog sum
    wire [FREQ_W:0]   analog_sum = {1'b0, analog_voltage_input} + {1'b0, analog_current_input};
    wire [FREQ_W-1:0] analog_ref = analog_sum[FREQ_W] ? {FREQ_W{1'b1}} : analog_sum[FREQ_W-1:0];
    wire              use_aux    = (cfg.aux_analog_function_select == AUX_FN_FREQ) & aux_enable;

    wire [FREQ_W-1:0] preset_ref =
        (step == 4'h0) ? (cfg.reference_source_select ? analog_ref : preset_frequency[0]) :
        (step == 4'h1) ? (use_aux ? aux_analog_input : preset_frequency[1]) :
                         preset_frequency[step];

    ////////////////////////////////////////////////////////////////////////
    // Source selection
    logic local_r;
    logic local_nxt;

    // Panel granted at once
    assign local_nxt = local_req ? 1'b1 : (drive_stopped ? 1'b0 : local_r);

    wire              src_run  = local_r ? panel_run :
                                 cfg.run_source_select ? serial_run : (term_run & ~conflict);
    wire              src_rev  = local_r ? panel_reverse :
                                 cfg.run_source_select ? serial_reverse : term_rev;
    wire [FREQ_W-1:0] src_freq = local_r ? panel_freq :
                                 cfg.run_source_select ? serial_freq : preset_ref;

    ////////////////////////////////////////////////////////////////////////
    // Jog and conflicting jog timer
    logic [JOG_CNT_W-1:0] jog_cnt_r;
    logic                 jog_stop_r;

    wire jog_both = fwd_jog & rev_jog;
    wire jog_dir  = fwd_jog | rev_jog;
    wire jog_sel  = fn_on[FN_JOG_SEL] & src_run;
    wire jog_any  = jog_dir | jog_sel;

    // Both jogs: keep direction
    wire jog_rev  = jog_both ? cmd.reverse : (jog_dir ? rev_jog : src_rev);
    wire jog_hit  = jog_both & (jog_cnt_r == JOG_CNT_W'(JOG_LIMIT - 1));

    ////////////////////////////////////////////////////////////////////////
    // Run request, baseblock, hold and fault latches
    logic             bb_stop_r;
    logic             hold_coast_r;
    logic             fault_r;
    logic [3:0]       fault_term_r;
    logic [FREQ_W-1:0] held_r;

    wire run_req    = src_run | jog_any;

    wire hold_drop  = ramp_hold & cmd.run & ~run_req;
    wire bb_decel   = baseblock & ramp_decelerating & cmd.run;
    wire jog_coast  = jog_stop_r & ~cfg.stop_method_select;

    wire fault_nxt  = ext_fault | (fault_r & ~fault_reset);
    wire bbs_nxt    = bb_decel | (bb_stop_r & run_req);
    wire holdc_nxt  = hold_drop | (hold_coast_r & ~run_req);
    wire jstop_nxt  = jog_hit | (jog_stop_r & jog_both);

    // Latched stops veto run
    wire run_ok     = run_req & ~baseblock & ~bbs_nxt & ~fault_nxt
                    & ~jstop_nxt & ~holdc_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Next command and indication
    dif_cmd_t    cmd_nxt;
    dif_ind_t    ind_nxt;
    logic [FREQ_W-1:0] freq_nxt;

    always_comb begin
        cmd_nxt                 = CMD_RST;
        cmd_nxt.run             = run_ok;
        cmd_nxt.reverse         = jog_any ? jog_rev : src_rev;
        cmd_nxt.jog             = jog_any & run_ok;
        cmd_nxt.ramp_second     = fn_on[FN_RAMP_SWITCH];
        cmd_nxt.ramp_hold       = ramp_hold;
        cmd_nxt.output_block    = baseblock | bbs_nxt | fault_nxt
                                | holdc_nxt | jog_coast;
        cmd_nxt.coast_stop      = bbs_nxt | fault_nxt | holdc_nxt | jog_coast;
        cmd_nxt.dc_brake        = fn_on[FN_DC_BRAKE] & drive_stopped & ~run_req;
        cmd_nxt.pid_enable      = pid_enable;
        cmd_nxt.pid_integ_reset = fn_on[FN_PID_IRESET];
        cmd_nxt.aux_enable      = aux_enable;
    end

    // Jog outranks sources
    assign freq_nxt = bbs_nxt ? '0 :
                      jog_any ? jog_frequency : src_freq;

    always_comb begin
        ind_nxt                = IND_RST;
        ind_nxt.fault          = fault_nxt;
        ind_nxt.fault_terminal = ext_fault ? fault_term : fault_term_r;
        ind_nxt.local_mode     = local_nxt;
        ind_nxt.remote_led     = ~local_nxt;
        if (fault_nxt) begin
            ind_nxt.display = DISP_EXT_FAULT;
        end else if (baseblock || bbs_nxt) begin
            ind_nxt.display = DISP_BB_ALARM;
        end else if (conflict && !local_r && !cfg.run_source_select) begin
            ind_nxt.display = DISP_FREQ_ERR;
        end else if (overheat) begin
            ind_nxt.display = DISP_OVERHEAT;
        end else begin
            ind_nxt.display = DISP_NORMAL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            run_st_r <= RUN_IDLE;
            local_r  <= 1'b0;
        end else if (clk_en) begin
            run_st_r <= run_st_nxt;
            local_r  <= local_nxt;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            jog_cnt_r  <= '0;
            jog_stop_r <= 1'b0;
        end else if (clk_en) begin
            jog_cnt_r  <= (jog_both && !jog_hit && !jog_stop_r) ? jog_cnt_r + 1'b1 : '0;
            jog_stop_r <= jstop_nxt;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bb_stop_r    <= 1'b0;
            hold_coast_r <= 1'b0;
            fault_r      <= 1'b0;
            fault_term_r <= 4'h0;
        end else if (clk_en) begin
            bb_stop_r    <= bbs_nxt;
            hold_coast_r <= holdc_nxt;
            fault_r      <= fault_nxt;
            fault_term_r <= ind_nxt.fault_terminal;
        end
    end

    // Kept for restart
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            held_r <= '0;
        end else if (clk_en && hold_drop) begin
            held_r <= output_frequency;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmd      <= CMD_RST;
            ind      <= IND_RST;
            freq_ref <= '0;
        end else if (clk_en) begin
            cmd      <= cmd_nxt;
            ind      <= ind_nxt;
            freq_ref <= freq_nxt;
        end
    end

    assign held_frequency = held_r;

endmodule // dif_decoder

// ---- dif_contacts.sv ----
// Model of the switches or controller on the contact inputs.
// Assumes requests change just after a rising mclk edge.
module dif_contacts
    import dif_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             slow,
    input  wire logic             f_i,
    input  wire logic             r_i,
    input  wire logic [NTERM-1:0] t_i,
    output logic                  fwd_o,
    output logic                  rev_o,
    output logic [NTERM-1:0]      pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NTERM+1:0] late_r;
    // Slow contacts close one clock late
    always_ff @(posedge mclk) late_r <= {t_i, r_i, f_i};
    assign {pins_o, rev_o, fwd_o} = slow ? late_r : {t_i, r_i, f_i};
endmodule // dif_contacts

// ---- dif_decoder_properties.sv ----
// Concurrent checks on the ports of the input decoder.
// Assumes clk_en held high and static configuration between changes.
module dif_decoder_properties
    import dif_pkg::*;
#(
    parameter int JOG_LIMIT = JOG_CONFLICT_CYCLES
) (
    input wire logic             mclk,
    input wire logic             nrst,
    input wire dif_cfg_t         cfg,
    input wire logic             forward_run_switch,
    input wire logic             reverse_run_switch,
    input wire logic [NTERM-1:0] term_pins,
    input wire logic             drive_stopped,
    input wire dif_cmd_t         cmd,
    input wire dif_ind_t         ind
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    function automatic logic pin_on(dif_cfg_t c, logic [NTERM-1:0] p, logic [FSEL_W-1:0] f);
        pin_on = 1'b0;
        for (int i = 0; i < NTERM; i++) if (c.term_fsel[i] == f && p[i]) pin_on = 1'b1;
    endfunction
    logic jog_both;
    int   jog_cnt;
    assign jog_both = pin_on(cfg, term_pins, FN_FWD_JOG) && pin_on(cfg, term_pins, FN_REV_JOG);
    // Cycles both jog contacts held
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) jog_cnt <= 0;
        else if (!jog_both) jog_cnt <= 0;
        else if (jog_cnt < JOG_LIMIT + 100) jog_cnt <= jog_cnt + 1;
    end
    ////////////////////////////////////////////////////////////////////
    chk_fault_blocks: assert property (ind.fault |-> cmd.output_block && !cmd.run)
        else $error("fault without output block");
    chk_fault_shown: assert property (ind.fault |-> ind.display == DISP_EXT_FAULT)
        else $error("fault not displayed");
    chk_remote_lamp: assert property (ind.remote_led == !ind.local_mode)
        else $error("remote lamp disagrees with mode");
    chk_remote_stopped: assert property ($fell(ind.local_mode) |-> $past(drive_stopped))
        else $error("left local mode while running");
    chk_dc_stopped: assert property (cmd.dc_brake |-> $past(drive_stopped) && !cmd.run)
        else $error("dc braking while running");
    chk_both_error: assert property ((forward_run_switch && reverse_run_switch && !cfg.run_source_select
        && !ind.local_mode) [*7] |-> !cmd.run && ind.display inside {DISP_FREQ_ERR, DISP_BB_ALARM,
        DISP_EXT_FAULT})
        else $error("both run contacts not refused");
    chk_bb_blocks: assert property (ind.display == DISP_BB_ALARM |-> cmd.output_block && !cmd.run)
        else $error("baseblock without output block");
    chk_jog_stop: assert property (jog_cnt > JOG_LIMIT + 6 |-> !cmd.run)
        else $error("jog conflict did not stop");
    chk_integ_reset: assert property (pin_on(cfg, term_pins, FN_PID_IRESET) [*7] |-> cmd.pid_integ_reset)
        else $error("integral reset not passed on");
    chk_pid_open: assert property (pin_on(cfg, term_pins, FN_PID_DISABLE) [*7] |-> !cmd.pid_enable)
        else $error("pid not disabled");
endmodule // dif_decoder_properties
bind dif_decoder dif_decoder_properties #(.JOG_LIMIT(JOG_LIMIT)) u_props (.mclk(mclk), .nrst(nrst),
    .cfg(cfg), .forward_run_switch(forward_run_switch), .reverse_run_switch(reverse_run_switch),
    .term_pins(term_pins), .drive_stopped(drive_stopped), .cmd(cmd), .ind(ind));

// ---- tb.sv ----
// Self-checking bench of the drive input decoder.
// Assumes the contact model and checker are compiled alongside.
module tb
    import dif_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                              mclk, nrst, slow, f_i, r_i, frst, prun, srun, srev, dstop, decel;
    logic [3:0]                        t_i;
    logic                              fwd, rev;
    logic [3:0]                        pins;
    dif_cfg_t                          cfg;
    logic [15:0]                       pf, sf, jf, av, ai, ax, of, fref, held;
    logic [NPRESET-1:0][FREQ_W-1:0]    pre;
    dif_cmd_t                          cmd;
    dif_ind_t                          ind;
    int                                fails, check_count;
    dif_contacts u_sw (.mclk(mclk), .slow(slow), .f_i(f_i), .r_i(r_i), .t_i(t_i),
        .fwd_o(fwd), .rev_o(rev), .pins_o(pins));
    dif_decoder #(.JOG_LIMIT(20)) u_dut (.mclk(mclk), .nrst(nrst), .clk_en(1'b1), .cfg(cfg),
        .forward_run_switch(fwd), .reverse_run_switch(rev), .term_pins(pins), .panel_run(prun),
        .panel_reverse(!srev), .panel_freq(pf), .serial_run(srun), .serial_reverse(srev), .serial_freq(sf),
        .preset_frequency(pre), .jog_frequency(jf), .analog_voltage_input(av), .analog_current_input(ai),
        .aux_analog_input(ax), .output_frequency(of), .drive_stopped(dstop), .ramp_decelerating(decel),
        .fault_reset(frst), .cmd(cmd), .freq_ref(fref), .held_frequency(held), .ind(ind));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic go();
        repeat (7) @(posedge mclk);
        #1;
    endtask
    task automatic drv(input logic f, input logic r, input logic [3:0] t);
        f_i = f;
        r_i = r;
        t_i = t;
        go();
    endtask
    function automatic logic [15:0] sat_sum(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[16] ? 16'hFFFF : s[15:0];
    endfunction
    task automatic end_sim();
        if (fails == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h3059E19B));
        {slow, f_i, r_i, t_i, frst, prun, srun, srev, decel} = '0;
        nrst = 1'b0;
        dstop = 1'b1;
        cfg = '0;
        cfg.term_fsel = {FN_STEP4, FN_STEP3, FN_STEP2, FN_STEP1};
        for (int i = 0; i < NPRESET; i++) pre[i] = 16'($urandom);
        {pf, sf, jf, ax, of} = {16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom)};
        av = 16'($urandom) | 16'h8000;
        ai = 16'($urandom) | 16'h8000;
        repeat (2) @(posedge mclk);
        #1 nrst = 1'b1;
        chk("ind", ind, IND_RST);
        drv(1, 0, 0); chk("run", cmd.run, 1); chk("rev", cmd.reverse, 0);
        drv(0, 1, 0); chk("run", cmd.run, 1); chk("rev", cmd.reverse, 1);
        drv(0, 0, 0); chk("run", cmd.run, 0);
        drv(1, 1, 0); chk("run", cmd.run, 0); chk("disp", ind.display, DISP_FREQ_ERR);
        drv(1, 0, 0); chk("run", cmd.run, 1); chk("disp", ind.display, DISP_NORMAL);
        for (int c = 2; c < NPRESET; c++) begin
            drv(1, 0, c[3:0]); chk("freq", fref, pre[c]);
        end
        drv(1, 0, 0); chk("freq", fref, pre[0]);
        cfg.reference_source_select = 1'b1; go(); chk("freq", fref, sat_sum(av, ai));
        drv(1, 0, 1); chk("freq", fref, ax);
        cfg.aux_analog_function_select = 4'h1; go(); chk("freq", fref, pre[1]);
        cfg.reference_source_select = 1'b0;
        drv(0, 0, 0); cfg.term_fsel[0] = FN_STOP_KEY;
        drv(1, 0, 0); drv(0, 0, 0); chk("run", cmd.run, 1);
        drv(0, 0, 1); chk("run", cmd.run, 0);
        drv(0, 0, 0); chk("run", cmd.run, 0);
        cfg.term_fsel = {FN_OVERHEAT, FN_BB_NO, FN_REV_JOG, FN_FWD_JOG};
        drv(1, 0, 1); chk("jog", cmd.jog, 1); chk("rev", cmd.reverse, 0); chk("freq", fref, jf);
        drv(0, 0, 2); chk("rev", cmd.reverse, 1); chk("freq", fref, jf);
        drv(0, 0, 3); chk("run", cmd.run, 1);
        repeat (25) @(posedge mclk);
        #1 chk("run", cmd.run, 0); chk("coast", cmd.coast_stop, 1);
        cfg.stop_method_select = 1'b1; drv(0, 0, 0); drv(0, 0, 3); repeat (4) go();
        chk("run", cmd.run, 0); chk("coast", cmd.coast_stop, 0);
        drv(1, 0, 0); drv(1, 0, 4); chk("blk", cmd.output_block, 1); chk("disp", ind.display, DISP_BB_ALARM);
        drv(1, 0, 0); chk("run", cmd.run, 1); chk("freq", fref, pre[0]);
        cfg.term_fsel[2] = FN_BB_NC; drv(1, 0, 4); chk("run", cmd.run, 1);
        drv(1, 0, 0); chk("blk", cmd.output_block, 1);
        cfg.term_fsel[2] = FN_BB_NO; go(); decel = 1'b1;
        drv(1, 0, 4); chk("freq", fref, 0); chk("coast", cmd.coast_stop, 1);
        drv(1, 0, 0); chk("run", cmd.run, 0);
        decel = 1'b0; drv(0, 0, 0); drv(1, 0, 8); chk("disp", ind.display, DISP_OVERHEAT); chk("run", cmd.run, 1);
        drv(1, 0, 0); chk("disp", ind.display, DISP_NORMAL);
        cfg.term_fsel = {FN_PID_DISABLE, FN_PID_IRESET, FN_RAMP_HOLD, FN_RAMP_SWITCH};
        cfg.pid_feature_enable = 1'b1;
        drv(1, 0, 1); chk("ramp2", cmd.ramp_second, 1);
        drv(1, 0, 0); chk("ramp2", cmd.ramp_second, 0); chk("pid", cmd.pid_enable, 1);
        drv(1, 0, 4); chk("ireset", cmd.pid_integ_reset, 1);
        drv(1, 0, 8); chk("pid", cmd.pid_enable, 0);
        drv(1, 0, 2); chk("hold", cmd.ramp_hold, 1);
        drv(0, 0, 2); chk("coast", cmd.coast_stop, 1); chk("held", held, of);
        drv(0, 0, 0); slow = 1'b1;
        cfg.term_fsel = {FN_LOCAL_SELECT, FN_DC_BRAKE, FN_AUX_ENABLE, FN_EXT_FAULT_NO};
        cfg.pid_feature_enable = 1'b0;
        drv(0, 0, 1); chk("fault", ind.fault, 1); chk("fterm", ind.fault_terminal, 4'h5);
        chk("disp", ind.display, DISP_EXT_FAULT); chk("blk", cmd.output_block, 1);
        drv(0, 0, 0); frst = 1'b1; go(); frst = 1'b0; chk("fault", ind.fault, 0);
        drv(0, 0, 2); chk("aux", cmd.aux_enable, 1);
        cfg.pid_feature_enable = 1'b1; go(); chk("aux", cmd.aux_enable, 0);
        cfg.pid_feature_enable = 1'b0; drv(0, 0, 0); chk("aux", cmd.aux_enable, 0);
        drv(0, 0, 4); chk("dc", cmd.dc_brake, 1);
        drv(1, 0, 4); chk("dc", cmd.dc_brake, 0); chk("run", cmd.run, 1);
        drv(0, 0, 0); prun = 1'b1;
        drv(0, 0, 8); chk("local", ind.local_mode, 1); chk("led", ind.remote_led, 0); chk("freq", fref, pf);
        chk("rev", cmd.reverse, 1);
        dstop = 1'b0; drv(0, 0, 0); chk("local", ind.local_mode, 1);
        dstop = 1'b1; go(); chk("local", ind.local_mode, 0); chk("led", ind.remote_led, 1);
        prun = 1'b0; cfg.run_source_select = 1'b1; srun = 1'b1; srev = 1'b1;
        go(); chk("run", cmd.run, 1); chk("rev", cmd.reverse, 1); chk("freq", fref, sf);
        end_sim();
    end
endmodule // tb
